// *** inc/ciw_regs.svh ***
/*
  register offsets, field positions, reset values, vectors and timing counts
  of the cpu interrupt and wait logic; assumes a 32-bit apb with byte addresses
*/
`ifndef CIW_REGS_SVH
`define CIW_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CIW_OFF_CTRL 8'h00
`define CIW_OFF_EXTPOL 8'h04
`define CIW_OFF_PINEN 8'h08
`define CIW_OFF_STATUS 8'h0C
`define CIW_OFF_PFLAG 8'h10
`define CIW_OFF_PASSOC 8'h14
`define CIW_OFF_PEN 8'h18

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define CIW_CTRL_MASK_BIT 0
`define CIW_CC_MASK_BIT 3
`define CIW_POL_RESET 4'h0
`define CIW_PINEN_RESET 15'h0000
`define CIW_PEN_RESET 17'h00000

// ----------------------------------------------------------------
// vectors, stack frame, timing
// ----------------------------------------------------------------
`define CIW_VEC_RESET 16'hFFFE
`define CIW_VEC_TRAP 16'hFFFC
`define CIW_VEC_EXT0 16'hFFF6
`define CIW_VEC_EXT1 16'hFFF4
`define CIW_VEC_EXT2 16'hFFF2
`define CIW_VEC_EXT3 16'hFFF0
`define CIW_VEC_SYNC 16'hFFEC
`define CIW_VEC_TMRA 16'hFFEA
`define CIW_VEC_TMRB 16'hFFE8
`define CIW_VEC_ASYNC 16'hFFE6
`define CIW_FRAME_BYTES 3'h5
`define CIW_HALT_STAB_CYCLES 4096

`endif

// *** inc/ciw_pkg.sv ***
/*
  types of the cpu interrupt and wait logic: sequencer states and the
  state records of the detector and flag bank; constants live in ciw_regs.svh
*/
package ciw_pkg;

  typedef enum logic [2:0] {
    CIW_RESET_VEC = 3'b000,
    CIW_RUN = 3'b001,
    CIW_PUSH = 3'b010,
    CIW_VECTOR = 3'b011,
    CIW_POP = 3'b100,
    CIW_WAIT = 3'b101,
    CIW_HALT = 3'b110,
    CIW_STAB = 3'b111
  } ciw_state_type;

  typedef struct packed {
    logic prev;
    logic latch;
    logic [1:0] pol;
    logic req;
  } ciw_det_type;

  typedef struct packed {
    logic [4:0] flags;
    logic [4:0] armed;
    logic req;
  } ciw_bank_type;

endpackage

// *** verilog/ciw_ext_detect.sv ***
/*
  one external interrupt line: ands its enabled pins and detects edge or
  low level as the polarity field selects; assumes pins are synchronous
*/
`timescale 1ns/1ps
`default_nettype none

module ciw_ext_detect #(
  parameter int W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [W-1:0] pins,
  input wire logic [W-1:0] pin_en,
  input wire logic [1:0] pol,
  input wire logic ack,
  output logic req
);
  import ciw_pkg::*;

  ciw_det_type s_reg;
  ciw_det_type s_next;
  logic level;

  // ----------------------------------------------------------------
  // detector
  // ----------------------------------------------------------------
  always_comb
  begin
    level = &(pins | ~pin_en);
    s_next = s_reg;
    s_next.prev = level;
    s_next.pol = pol;
    if (ack)
    begin
      s_next.latch = 1'b0;
    end
    // polarity change drops the request
    if (pol != s_reg.pol)
    begin
      s_next.latch = 1'b0;
    end
    else if ((s_reg.prev && !level && pol != 2'b01) ||
             (!s_reg.prev && level && pol[0]))
    begin
      s_next.latch = 1'b1;
    end
    s_next.req = s_next.latch | (pol == 2'b00 && !level);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '{prev: 1'b1, latch: 1'b0, pol: 2'b00, req: 1'b0};
    end
    else if (ce)
    begin
      s_reg <= s_next;
    end
  end

  assign req = s_reg.req;

endmodule // ciw_ext_detect

`default_nettype wire

// *** verilog/ciw_flag_bank.sv ***
/*
  peripheral interrupt flags of one source: set by the peripheral, cleared
  by writing zero or by the status access then associated access sequence
*/
`timescale 1ns/1ps
`default_nettype none

module ciw_flag_bank #(
  parameter int N = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [N-1:0] set,
  input wire logic [N-1:0] enable,
  input wire logic stat_rd,
  input wire logic stat_wr,
  input wire logic [N-1:0] wdata,
  input wire logic assoc,
  output logic [N-1:0] flags,
  output logic req
);
  import ciw_pkg::*;

  ciw_bank_type s_reg;
  ciw_bank_type s_next;
  logic [N-1:0] clr;

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    clr = '0;
    if (stat_wr)
    begin
      clr = ~wdata;
    end
    if (assoc)
    begin
      clr = clr | s_reg.armed[N-1:0];
      s_next.armed = '0;
    end
    if (stat_rd)
    begin
      s_next.armed[N-1:0] = s_reg.flags[N-1:0];
    end
    // set wins over a clear in the same cycle
    s_next.flags[N-1:0] = (s_reg.flags[N-1:0] & ~clr) | set;
    s_next.req = |(s_next.flags[N-1:0] & enable);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '0;
    end
    else if (ce)
    begin
      s_reg <= s_next;
    end
  end

  assign flags = s_reg.flags[N-1:0];
  assign req = s_reg.req;

endmodule // ciw_flag_bank

`default_nettype wire

// *** verilog/ciw_core.sv ***
/*
  interrupt entry and return sequencing, mask bit, fixed priority vectors,
  external line detection, peripheral flags, wait and halt exit.
  assumes the cpu sequencer pulses instr_end at each instruction boundary,
  with trap_exec, ret_exec, wait_exec or halt_exec beside it, and follows
  stall, push, pop and pc_load; apb slave per amba apb.
*/
// Notes on behaviour
// - entry pushes context, masks, loads vector
// - mask set on entry blocks nesting
// - return pops context, restores mask bit
// - maskable requests wait while mask set
// - fixed priority, reset highest, serial lowest
// - trap always enters, ignores mask
// - line 0 and line 1 vectors
// - line 2 and line 3 vectors
// - only reset and external lines end halt
// - external vector needs event and clear mask
// - edge request latched, cleared on entry
// - shared pins anded before detector
// - low pin blocks even rising edge
// - peripheral needs enable and clear mask
// - clearing sequence discards pending request
// - wait stops cpu, clears mask
// - every source ends wait
// - entry takes five stack bytes
`timescale 1ns/1ps
`default_nettype none
`include "ciw_regs.svh"

module ciw_core #(
  parameter int STAB_CYCLES = `CIW_HALT_STAB_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_end,
  input wire logic trap_exec,
  input wire logic ret_exec,
  input wire logic wait_exec,
  input wire logic halt_exec,
  input wire logic [7:0] pop_data,
  input wire logic [3:0] ext_pins_line0,
  input wire logic [2:0] ext_pins_line1,
  input wire logic [3:0] ext_pins_line2,
  input wire logic [3:0] ext_pins_line3,
  input wire logic [16:0] per_flag_set,
  output logic cpu_stall,
  output logic stack_push,
  output logic stack_pop,
  output logic [2:0] stack_slot,
  output logic resume_next,
  output logic pc_load,
  output logic [15:0] vector_addr,
  output logic mask_bit,
  output logic in_wait,
  output logic in_halt
);
  import ciw_pkg::*;

  typedef struct packed {
    ciw_state_type state;
    logic mask;
    logic [15:0] stab;
    logic [15:0] vec;
    logic [3:0] ack_sel;
    logic from_wait;
    logic stall;
    logic push;
    logic pop;
    logic [2:0] slot;
    logic pc_load;
    logic in_wait;
    logic in_halt;
    logic [3:0] ext_ack;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [3:0] pol;
    logic [14:0] pin_en;
    logic [16:0] pen;
    logic stat_rd;
    logic stat_wr;
    logic assoc;
  } ciw_core_type;

  ciw_core_type s_reg;
  ciw_core_type s_next;
  logic [3:0] ext_req;
  logic [3:0] per_req;
  logic [16:0] flags;
  logic any_mask_req;
  logic [15:0] sel_vec;
  logic [3:0] sel_ack;
  logic apb_done;
  logic [15:0] stab_last;

  assign stab_last = 16'(STAB_CYCLES - 1);

  // ----------------------------------------------------------------
  // external lines
  // ----------------------------------------------------------------
  ciw_ext_detect #(.W(4)) u_ext_line_0 (
    .pclk(pclk),
    .presetn(presetn),
    .ce(pclk_en),
    .pins(ext_pins_line0),
    .pin_en(s_reg.pin_en[3:0]),
    .pol(s_reg.pol[1:0]),
    .ack(s_reg.ext_ack[0]),
    .req(ext_req[0])
  );

  ciw_ext_detect #(.W(3)) u_ext_line_1 (
    .pclk(pclk),
    .presetn(presetn),
    .ce(pclk_en),
    .pins(ext_pins_line1),
    .pin_en(s_reg.pin_en[6:4]),
    .pol(s_reg.pol[1:0]),
    .ack(s_reg.ext_ack[1]),
    .req(ext_req[1])
  );

  ciw_ext_detect #(.W(4)) u_ext_line_2 (
    .pclk(pclk),
    .presetn(presetn),
    .ce(pclk_en),
    .pins(ext_pins_line2),
    .pin_en(s_reg.pin_en[10:7]),
    .pol(s_reg.pol[3:2]),
    .ack(s_reg.ext_ack[2]),
    .req(ext_req[2])
  );

  ciw_ext_detect #(.W(4)) u_ext_line_3 (
    .pclk(pclk),
    .presetn(presetn),
    .ce(pclk_en),
    .pins(ext_pins_line3),
    .pin_en(s_reg.pin_en[14:11]),
    .pol(s_reg.pol[3:2]),
    .ack(s_reg.ext_ack[3]),
    .req(ext_req[3])
  );

  // ----------------------------------------------------------------
  // peripheral flags
  // ----------------------------------------------------------------
  ciw_flag_bank #(.N(2)) u_flags_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(pclk_en),
    .set(per_flag_set[1:0]),
    .enable(s_reg.pen[1:0]),
    .stat_rd(s_reg.stat_rd),
    .stat_wr(s_reg.stat_wr),
    .wdata(pwdata[1:0]),
    .assoc(s_reg.assoc),
    .flags(flags[1:0]),
    .req(per_req[0])
  );

  ciw_flag_bank #(.N(5)) u_flags_tmra (
    .pclk(pclk),
    .presetn(presetn),
    .ce(pclk_en),
    .set(per_flag_set[6:2]),
    .enable(s_reg.pen[6:2]),
    .stat_rd(s_reg.stat_rd),
    .stat_wr(s_reg.stat_wr),
    .wdata(pwdata[6:2]),
    .assoc(s_reg.assoc),
    .flags(flags[6:2]),
    .req(per_req[1])
  );

  ciw_flag_bank #(.N(5)) u_flags_tmrb (
    .pclk(pclk),
    .presetn(presetn),
    .ce(pclk_en),
    .set(per_flag_set[11:7]),
    .enable(s_reg.pen[11:7]),
    .stat_rd(s_reg.stat_rd),
    .stat_wr(s_reg.stat_wr),
    .wdata(pwdata[11:7]),
    .assoc(s_reg.assoc),
    .flags(flags[11:7]),
    .req(per_req[2])
  );

  // five async serial events, one request
  ciw_flag_bank #(.N(5)) u_flags_async (
    .pclk(pclk),
    .presetn(presetn),
    .ce(pclk_en),
    .set(per_flag_set[16:12]),
    .enable(s_reg.pen[16:12]),
    .stat_rd(s_reg.stat_rd),
    .stat_wr(s_reg.stat_wr),
    .wdata(pwdata[16:12]),
    .assoc(s_reg.assoc),
    .flags(flags[16:12]),
    .req(per_req[3])
  );

  // ----------------------------------------------------------------
  // priority select
  // ----------------------------------------------------------------
  always_comb
  begin
    any_mask_req = |ext_req | |per_req;
    sel_ack = 4'h0;
    // fixed order, lowest is async serial
    if (ext_req[0])
    begin
      sel_vec = `CIW_VEC_EXT0;
      sel_ack = 4'h1;
    end
    else if (ext_req[1])
    begin
      sel_vec = `CIW_VEC_EXT1;
      sel_ack = 4'h2;
    end
    else if (ext_req[2])
    begin
      sel_vec = `CIW_VEC_EXT2;
      sel_ack = 4'h4;
    end
    else if (ext_req[3])
    begin
      sel_vec = `CIW_VEC_EXT3;
      sel_ack = 4'h8;
    end
    else if (per_req[0])
    begin
      sel_vec = `CIW_VEC_SYNC;
    end
    else if (per_req[1])
    begin
      sel_vec = `CIW_VEC_TMRA;
    end
    else if (per_req[2])
    begin
      sel_vec = `CIW_VEC_TMRB;
    end
    else
    begin
      sel_vec = `CIW_VEC_ASYNC;
    end
  end

  // ----------------------------------------------------------------
  // sequencer and register file
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.pc_load = 1'b0;
    s_next.ext_ack = 4'h0;
    s_next.stat_rd = 1'b0;
    s_next.stat_wr = 1'b0;
    s_next.assoc = 1'b0;
    unique case (s_reg.state)
      CIW_RESET_VEC:
      begin
        // reset vector loads without a stack frame
        s_next.pc_load = 1'b1;
        s_next.vec = `CIW_VEC_RESET;
        s_next.state = CIW_VECTOR;
      end
      CIW_RUN:
      begin
        if (instr_end)
        begin
          if (trap_exec)
          begin
            s_next.vec = `CIW_VEC_TRAP;
            s_next.ack_sel = 4'h0;
            s_next.state = CIW_PUSH;
          end
          else if (ret_exec)
          begin
            s_next.state = CIW_POP;
            s_next.pop = 1'b1;
          end
          else if (wait_exec)
          begin
            s_next.state = CIW_WAIT;
            s_next.mask = 1'b0;
            s_next.in_wait = 1'b1;
          end
          else if (halt_exec)
          begin
            s_next.state = CIW_HALT;
            s_next.mask = 1'b0;
            s_next.in_halt = 1'b1;
          end
          // external needs event and clear mask
          else if (!s_reg.mask && any_mask_req)
          begin
            s_next.vec = sel_vec;
            s_next.ack_sel = sel_ack;
            s_next.state = CIW_PUSH;
          end
          s_next.stall = (s_next.state != CIW_RUN);
          s_next.push = (s_next.state == CIW_PUSH);
          s_next.slot = 3'h0;
          s_next.from_wait = 1'b0;
        end
      end
      CIW_PUSH:
      begin
        if (s_reg.slot == `CIW_FRAME_BYTES - 3'h1)
        begin
          // mask and vector after the frame
          s_next.push = 1'b0;
          s_next.mask = 1'b1;
          s_next.pc_load = 1'b1;
          s_next.ext_ack = s_reg.ack_sel;
          s_next.state = CIW_VECTOR;
        end
        else
        begin
          s_next.slot = s_reg.slot + 3'h1;
        end
      end
      CIW_VECTOR:
      begin
        s_next.stall = 1'b0;
        s_next.from_wait = 1'b0;
        s_next.state = CIW_RUN;
      end
      CIW_POP:
      begin
        // mask comes back from the saved cc
        if (s_reg.slot == 3'h0)
        begin
          s_next.mask = pop_data[`CIW_CC_MASK_BIT];
        end
        if (s_reg.slot == `CIW_FRAME_BYTES - 3'h1)
        begin
          s_next.pop = 1'b0;
          s_next.stall = 1'b0;
          s_next.state = CIW_RUN;
        end
        else
        begin
          s_next.slot = s_reg.slot + 3'h1;
        end
      end
      CIW_WAIT:
      begin
        // push the address past the wait
        if (any_mask_req)
        begin
          s_next.vec = sel_vec;
          s_next.ack_sel = sel_ack;
          s_next.from_wait = 1'b1;
          s_next.in_wait = 1'b0;
          s_next.push = 1'b1;
          s_next.slot = 3'h0;
          s_next.state = CIW_PUSH;
        end
      end
      CIW_HALT:
      begin
        if (|ext_req)
        begin
          s_next.stab = 16'h0000;
          s_next.state = CIW_STAB;
        end
      end
      CIW_STAB:
      begin
        // oscillator restart delay before servicing
        if (s_reg.stab == stab_last)
        begin
          s_next.in_halt = 1'b0;
          s_next.from_wait = 1'b1;
          s_next.vec = sel_vec;
          s_next.ack_sel = sel_ack;
          s_next.slot = 3'h0;
          s_next.push = any_mask_req;
          s_next.stall = any_mask_req;
          s_next.state = any_mask_req ? CIW_PUSH : CIW_RUN;
        end
        else
        begin
          s_next.stab = s_reg.stab + 16'h0001;
        end
      end
    endcase

    // apb: one wait state, register writes at the completing edge, flag arm and clear one edge later
    apb_done = psel && penable && s_reg.pready;
    s_next.pready = psel && penable && !s_reg.pready;
    if (psel && penable && !s_reg.pready)
    begin
      s_next.pslverr = 1'b0;
      s_next.prdata = 32'h0000_0000;
      unique case (paddr)
        `CIW_OFF_CTRL: s_next.prdata[`CIW_CTRL_MASK_BIT] = s_reg.mask;
        `CIW_OFF_EXTPOL: s_next.prdata[3:0] = s_reg.pol;
        `CIW_OFF_PINEN: s_next.prdata[14:0] = s_reg.pin_en;
        `CIW_OFF_STATUS: s_next.prdata = {s_reg.vec, 4'h0, per_req, ext_req, s_reg.mask,
                                          s_reg.state};
        `CIW_OFF_PFLAG: s_next.prdata[16:0] = flags;
        `CIW_OFF_PASSOC: s_next.prdata = 32'h0000_0000;
        `CIW_OFF_PEN: s_next.prdata[16:0] = s_reg.pen;
        default: s_next.pslverr = 1'b1;
      endcase
    end
    if (apb_done && !s_reg.pslverr)
    begin
      // status access arms, write zero clears
      s_next.stat_rd = (paddr == `CIW_OFF_PFLAG);
      s_next.stat_wr = pwrite && (paddr == `CIW_OFF_PFLAG);
      s_next.assoc = (paddr == `CIW_OFF_PASSOC);
      // the mask set by an entry wins over a write in the same cycle
      if (pwrite)
      begin
        unique case (paddr)
          `CIW_OFF_CTRL: s_next.mask = pwdata[`CIW_CTRL_MASK_BIT] | s_next.pc_load;
          `CIW_OFF_EXTPOL: s_next.pol = pwdata[3:0];
          `CIW_OFF_PINEN: s_next.pin_en = pwdata[14:0];
          `CIW_OFF_PEN: s_next.pen = pwdata[16:0];
          default: s_next.pol = s_next.pol;
        endcase
      end
    end
    if (!apb_done && !s_next.pready)
    begin
      s_next.pslverr = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '0;
      s_reg.state <= CIW_RESET_VEC;
      s_reg.mask <= 1'b1;
      s_reg.stall <= 1'b1;
      s_reg.pol <= `CIW_POL_RESET;
      s_reg.pin_en <= `CIW_PINEN_RESET;
      s_reg.pen <= `CIW_PEN_RESET;
    end
    else if (pclk_en)
    begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign cpu_stall = s_reg.stall;
  assign stack_push = s_reg.push;
  assign stack_pop = s_reg.pop;
  assign stack_slot = s_reg.slot;
  assign resume_next = s_reg.from_wait;
  assign pc_load = s_reg.pc_load;
  assign vector_addr = s_reg.vec;
  assign mask_bit = s_reg.mask;
  assign in_wait = s_reg.in_wait;
  assign in_halt = s_reg.in_halt;

endmodule // ciw_core

`default_nettype wire

// *** testbench/ciw_cpu_model.sv ***
/*
  cpu sequencer model: boundaries, exec pulses, popped bytes.
  assumes the core follows its stall, push and pop contract.
*/
`timescale 1ns/1ps
`default_nettype none
module ciw_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] cmd,
  input wire logic cpu_stall,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic [2:0] stack_slot,
  input wire logic mask_bit,
  output logic taken,
  output logic instr_end,
  output logic [3:0] exec,
  output logic [7:0] pop_data
);
  logic go;
  logic cc_mask;
  logic flip;
  assign go = !cpu_stall && !instr_end;
  // released lane toggles so a stale byte never looks valid
  assign pop_data = stack_pop ? {4'h0, cc_mask, 3'h0} : {8{flip}};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instr_end <= 1'b0;
      exec <= 4'h0;
      taken <= 1'b0;
      cc_mask <= 1'b0;
      flip <= 1'b0;
    end
    else
    begin
      instr_end <= go;
      exec <= (go && cmd != 3'h0) ? 4'h1 << (cmd - 3'h1) : 4'h0;
      taken <= go && cmd != 3'h0;
      flip <= !flip;
      if (stack_push && stack_slot == 3'h4)
        cc_mask <= mask_bit;
    end
  end
endmodule // ciw_cpu_model
`default_nettype wire

// *** testbench/ciw_core_properties.sv ***
/*
  checks on the core's sequencing ports.
  assumes pclk_en only drops while the core idles.
*/
`timescale 1ns/1ps
`default_nettype none
module ciw_core_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic instr_end,
  input wire logic trap_exec,
  input wire logic [7:0] pop_data,
  input wire logic cpu_stall,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic [2:0] stack_slot,
  input wire logic pc_load,
  input wire logic [15:0] vector_addr,
  input wire logic mask_bit,
  input wire logic in_wait,
  input wire logic in_halt
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic run;
  assign run = !cpu_stall && !in_wait && !in_halt;
  a_trap_enters: assert property (instr_end && trap_exec && run |=>
    stack_push ##5 pc_load && vector_addr == 16'hFFFC) else $error("trap entry wrong");
  a_slot_order: assert property ($rose(stack_push) |-> stack_slot == 3'h0
    ##1 stack_slot == 3'h1 ##1 stack_slot == 3'h2 ##1 stack_slot == 3'h3
    ##1 stack_slot == 3'h4) else $error("push order wrong");
  a_push_five: assert property ($rose(stack_push) |-> stack_push[*5]
    ##1 !stack_push && pc_load) else $error("push length wrong");
  a_entry_masks: assert property (pc_load |-> mask_bit ##1 !pc_load)
    else $error("mask clear on entry");
  a_mask_gate: assert property (instr_end && !trap_exec && mask_bit && run |=>
    !$rose(stack_push)) else $error("masked entry");
  a_pop_five: assert property ($rose(stack_pop) |-> stack_pop[*5] ##1 !stack_pop)
    else $error("pop length wrong");
  a_ret_mask: assert property (stack_pop && stack_slot == 3'h0 |=>
    mask_bit == $past(pop_data[3])) else $error("mask not restored");
  a_wait_unmask: assert property ($rose(in_wait) |-> !mask_bit)
    else $error("mask set in wait");
  a_vec_legal: assert property (pc_load |-> vector_addr inside {16'hFFFE, 16'hFFFC,
    16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFF0, 16'hFFEC, 16'hFFEA, 16'hFFE8, 16'hFFE6})
    else $error("bad vector");
  c_trap: cover property (pc_load && vector_addr == 16'hFFFC);
  c_wake: cover property (in_wait ##1 stack_push);
  c_halt: cover property ($rose(in_halt));
endmodule // ciw_core_properties

bind ciw_core ciw_core_properties u_props (
  .pclk, .presetn, .instr_end, .trap_exec, .pop_data, .cpu_stall, .stack_push,
  .stack_pop, .stack_slot, .pc_load, .vector_addr, .mask_bit, .in_wait, .in_halt
);
`default_nettype wire

// *** testbench/tb.sv ***
/*
  self-checking bench of the interrupt and wait core.
  assumes the cpu model drives sequencing.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk, presetn, pclk_en, psel, penable, pwrite, pready, pslverr, instr_end, taken;
  logic cpu_stall, stack_push, stack_pop, resume_next, pc_load, mask_bit, in_wait, in_halt;
  logic [2:0] cmd, stack_slot;
  logic [3:0] exec;
  logic [7:0] paddr, pop_data;
  logic [14:0] pins;
  logic [15:0] vector_addr;
  logic [16:0] per_flag_set;
  logic [31:0] pwdata, prdata, rd;
  int errors, compares, cyc;
  ciw_core #(.STAB_CYCLES(8)) DUT (
    .pclk, .presetn, .pclk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .instr_end, .trap_exec(exec[0]), .ret_exec(exec[1]),
    .wait_exec(exec[2]), .halt_exec(exec[3]), .pop_data, .ext_pins_line0(pins[3:0]),
    .ext_pins_line1(pins[6:4]), .ext_pins_line2(pins[10:7]), .ext_pins_line3(pins[14:11]),
    .per_flag_set, .cpu_stall, .stack_push, .stack_pop, .stack_slot, .resume_next,
    .pc_load, .vector_addr, .mask_bit, .in_wait, .in_halt
  );
  ciw_cpu_model u_cpu (
    .pclk, .presetn, .cmd, .cpu_stall, .stack_push, .stack_pop, .stack_slot,
    .mask_bit, .taken, .instr_end, .exec, .pop_data
  );
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    chk("pslverr", {31'h0, a > 8'h18}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic op(input logic [2:0] c);
    cmd <= c;
    do @(posedge pclk); while (taken !== 1'b1);
    cmd <= 3'h0;
  endtask
  task automatic entry(input logic [15:0] v, input logic r);
    int n;
    n = 0;
    while (pc_load !== 1'b1)
    begin
      n += (stack_push === 1'b1);
      @(posedge pclk);
    end
    chk("vector", v, vector_addr);
    chk("stack bytes", 5, n);
    chk("entry mask", 1, mask_bit);
    chk("resume", r, resume_next);
    chk("entry stall", 1, cpu_stall);
  endtask
  task automatic ret(input logic m);
    op(3'h2);
    repeat (6) @(posedge pclk);
    chk("return mask", m, mask_bit);
  endtask
  task automatic quiet(input int k);
    repeat (k)
    begin
      @(posedge pclk);
      chk("no entry", 0, stack_push);
    end
  endtask
  task automatic flag(input int b);
    per_flag_set <= 17'h1 << b;
    @(posedge pclk);
    per_flag_set <= 17'h0;
  endtask
  task automatic t_regs();
    apb(0, 8'h18, 0);
    chk("enable reset", 0, rd);
    apb(0, 8'h1C, 0);
    apb(1, 8'h00, 0);
    chk("mask cleared", 0, mask_bit);
  endtask
  task automatic t_trap();
    apb(1, 8'h00, 1);
    op(3'h1);
    entry(16'hFFFC, 0);
    ret(1);
    apb(1, 8'h00, 0);
  endtask
  task automatic t_ext();
    apb(1, 8'h04, 32'hA);
    apb(1, 8'h08, 32'h7FFF);
    apb(1, 8'h00, 1);
    pins <= 15'h77EE;
    quiet(20);
    pins <= 15'h7FFF;
    apb(1, 8'h00, 0);
    entry(16'hFFF6, 0);
    ret(0);
    entry(16'hFFF4, 0);
    ret(0);
    entry(16'hFFF0, 0);
    ret(0);
    quiet(20);
  endtask
  task automatic t_and();
    apb(1, 8'h04, 32'h6);
    pins <= 15'h7F7F;
    @(posedge pclk);
    pins <= 15'h7E7F;
    @(posedge pclk);
    pins <= 15'h7F7F;
    quiet(20);
    pins <= 15'h7FFF;
    entry(16'hFFF2, 0);
    ret(0);
  endtask
  task automatic t_per();
    flag(12);
    quiet(20);
    apb(0, 8'h10, 0);
    chk("pending flag", 32'h1000, rd);
    apb(0, 8'h14, 0);
    apb(1, 8'h18, 32'h11080);
    quiet(20);
    flag(16);
    entry(16'hFFE6, 0);
    apb(1, 8'h10, 0);
    ret(0);
    quiet(20);
  endtask
  task automatic t_wait();
    apb(1, 8'h00, 1);
    op(3'h3);
    repeat (3) @(posedge pclk);
    chk("in wait", 1, in_wait);
    chk("wait mask", 0, mask_bit);
    flag(7);
    entry(16'hFFE8, 1);
    chk("wait exit", 0, in_wait);
    apb(1, 8'h10, 0);
    ret(0);
  endtask
  task automatic t_halt();
    op(3'h4);
    flag(12);
    quiet(30);
    chk("in halt", 1, in_halt);
    pins <= 15'h7FFE;
    entry(16'hFFF6, 1);
    chk("halt exit", 0, in_halt);
    pins <= 15'h7FFF;
    apb(1, 8'h10, 0);
    ret(0);
  endtask
  task automatic t_freeze();
    pclk_en <= 1'b0;
    pins <= 15'h7FFE;
    repeat (4) @(posedge pclk);
    pins <= 15'h7FFF;
    repeat (2) @(posedge pclk);
    pclk_en <= 1'b1;
    quiet(20);
  endtask
  task automatic t_modes();
    apb(1, 8'h04, 32'hF);
    pins <= 15'h7F7F;
    entry(16'hFFF2, 0);
    pins <= 15'h7FFF;
    ret(0);
    entry(16'hFFF2, 0);
    ret(0);
    apb(1, 8'h04, 32'h0);
    pins <= 15'h7FFE;
    entry(16'hFFF6, 0);
    ret(0);
    entry(16'hFFF6, 0);
    pins <= 15'h7FFF;
    ret(0);
  endtask
  initial
  begin
    presetn = 1'b0;
    pclk_en = 1'b1;
    {psel, penable, pwrite} = 3'b000;
    paddr = 8'h00;
    pwdata = 32'h0;
    pins = 15'h7FFF;
    per_flag_set = 17'h0;
    cmd = 3'h0;
    errors = 0;
    compares = 0;
    cyc = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    do @(posedge pclk); while (pc_load !== 1'b1);
    chk("reset vector", 16'hFFFE, vector_addr);
    repeat (3) @(posedge pclk);
    t_regs();
    t_trap();
    t_ext();
    t_and();
    t_freeze();
    t_per();
    t_wait();
    t_halt();
    t_modes();
    finish_test();
  end
endmodule // tb
`default_nettype wire
